// File: logic/link_sync2.sv
// Two-flop synchroniser for one link-side level
`timescale 1ns/1ps
module link_sync2 #(
  parameter logic RST_VAL = 1'h0
) (
  input  wire logic core_clk_in,
  input  wire logic rst_in,
  input  wire logic async_in,
  output logic      sync_out
);

  typedef struct packed {
    logic s1;
    logic s2;
  } sync_state_type;

  sync_state_type st_r;
  sync_state_type st_nxt;

  // First stage feeds only the second stage
  always_comb begin
    st_nxt    = st_r;
    st_nxt.s1 = async_in;
    st_nxt.s2 = st_r.s1;
  end

  // State register
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      st_r.s1 <= RST_VAL;
      st_r.s2 <= RST_VAL;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign sync_out = st_r.s2;

endmodule

// File: logic/packet_shift_out.sv
// Serial shifter that hands one 32-bit packet to the host, MSB first
`timescale 1ns/1ps
module packet_shift_out (
  input  wire logic        core_clk_in,
  input  wire logic        rst_in,
  input  wire logic        load_in,
  input  wire logic [31:0] word_in,
  input  wire logic        sclk_in,
  input  wire logic        sel_n_in,
  output logic             data_out,
  output logic             oe_out,
  output logic             ready_out,
  output logic             done_out
);

  typedef struct packed {
    logic [31:0] word;
    logic [31:0] sh;
    logic [5:0]  cnt;
    logic        loaded;
    logic        sclk_prev;
    logic        oe;
    logic        done;
  } shift_state_type;

  shift_state_type st_r;
  shift_state_type st_nxt;
  logic            rise;
  logic            fall;

  // Edges of the already synchronised link clock
  assign rise = sclk_in & ~st_r.sclk_prev;
  assign fall = ~sclk_in & st_r.sclk_prev;

  // ----------------------------------------------------------------
  // Shift control
  // ----------------------------------------------------------------
  // Deselect rewinds, so an aborted read is simply repeated whole
  always_comb begin
    st_nxt           = st_r;
    st_nxt.done      = 1'h0;
    st_nxt.sclk_prev = sclk_in;
    if (load_in) begin
      st_nxt.word   = word_in;
      st_nxt.sh     = word_in;
      st_nxt.cnt    = 6'h00;
      st_nxt.loaded = 1'h1;
    end else if (sel_n_in && st_r.loaded) begin
      st_nxt.sh  = st_r.word;
      st_nxt.cnt = 6'h00;
    end else if (st_r.loaded) begin
      if (rise) begin
        if (st_r.cnt == pvpf_pkg::PKT_LAST_BIT) begin
          st_nxt.loaded = 1'h0;
          st_nxt.done   = 1'h1;
          st_nxt.cnt    = 6'h00;
          st_nxt.sh     = pvpf_pkg::WORD_RST;
        end else begin
          st_nxt.cnt = st_r.cnt + 6'h01;
        end
      end else if (fall && st_r.cnt != 6'h00) begin
        st_nxt.sh = {st_r.sh[30:0], 1'h0};
      end
    end
    st_nxt.oe = ~sel_n_in & st_nxt.loaded;
  end

  // State register
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign data_out  = st_r.sh[31];
  assign oe_out    = st_r.oe;
  assign ready_out = st_r.loaded;
  assign done_out  = st_r.done;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (rst_in);

  sequence s_last_rise;
    !load_in && !sel_n_in && st_r.loaded && rise && st_r.cnt == 6'h1F;
  endsequence

  AST_SHIFT_MSB_FIRST: assert property (
    (!load_in && !sel_n_in && st_r.loaded && fall && st_r.cnt != 6'h00)
      |=> (data_out == $past(st_r.sh[30]))
  ) else $error("shifter did not advance to next bit");

  AST_DONE_AFTER_32: assert property (
    s_last_rise |=> (done_out && !ready_out) ##1 !done_out
  ) else $error("packet end not flagged after 32 bits");

  // Without a packet the line must rest low, not replay the old word
  AST_IDLE_LINE_LOW: assert property (
    !ready_out |-> !data_out
  ) else $error("data line not low without a packet");

endmodule

// File: logic/paging_vector_packet_formatter.sv
// Vector packet formatter: register file, packet builder and link control
// Notes on behaviour
// - Short vector message type picks data meaning
// - Type 01: source code low, rest unused
// - Type 10: source, message number, retrieval flag
// - Short vector on long address: five chars follow
// - Four-byte numeric layout, byte three first
// - Numeric types 011, 100, 111
// - Seven-bit slot index, valid 2 to 87
// - Error flag: bit errors, check fail, invalid
// - Two-bit phase code, a to d
// - Four check bits in byte one
// - Numeric count is length minus one
// - Long address: first word follows vector
// - Start word field, valid 3 to 87
// - Block vectors carry seven-bit word count
// - Short vector type code 010
// - Secure 000, alphanumeric 101, hex 110
// - No follow-on packet when error set
//
// The implementer's own choices: register access over Avalon-MM and the placing of the registers.
`timescale 1ns/1ps
module paging_vector_packet_formatter (
  input  wire logic        core_clk_in,
  input  wire logic        rst_in,
  input  wire logic [4:0]  avs_address_in,
  input  wire logic        avs_read_in,
  input  wire logic        avs_write_in,
  input  wire logic [31:0] avs_writedata_in,
  input  wire logic [3:0]  avs_byteenable_in,
  output logic      [31:0] avs_readdata_out,
  output logic             avs_waitrequest_out,
  input  wire logic        link_clk_in,
  input  wire logic        link_sel_n_in,
  output logic             link_data_out,
  output logic             link_data_oe_out,
  output logic             link_ready_out
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        wait_r;
    logic [31:0] rdata;
    logic [31:0] vec;
    logic [31:0] num;
    logic [31:0] shrt;
    logic [31:0] extra;
    logic [31:0] last_pkt;
    logic [31:0] ext_word;
    logic [31:0] load_word;
    logic        load;
    logic        busy;
    logic        extra_pend;
    logic        last_err;
  } fmt_state_type;

  fmt_state_type st_r;
  fmt_state_type st_nxt;

  logic        sclk_s;
  logic        sel_n_s;
  logic        sh_done;
  logic        sh_ready;
  logic        accept;
  logic        launch;
  logic [31:0] wmask;
  logic [6:0]  slot;
  logic [6:0]  slot_next;
  logic [1:0]  phase;
  logic [2:0]  vtype;
  logic        long_addr;
  logic [1:0]  bit_errs;
  logic        chk_fail;
  logic [3:0]  chk;
  logic [6:0]  len;
  logic [6:0]  len_m1;
  logic [6:0]  start;
  logic [1:0]  mtype;
  logic [11:0] chars;
  logic [2:0]  src;
  logic [5:0]  msgnum;
  logic        retr;
  logic        is_short;
  logic        is_num;
  logic        is_blk;
  logic        slot_bad;
  logic        start_bad;
  logic        len_bad;
  logic        invalid;
  logic        vec_err;
  logic [11:0] short_data;
  logic [15:0] pkt_body;
  logic [31:0] packet;
  logic [31:0] extra_word;

  // ----------------------------------------------------------------
  // Link pin synchronisers
  // ----------------------------------------------------------------
  link_sync2 #(
    .RST_VAL (1'h0)
  ) u_sync_clk (
    .core_clk_in (core_clk_in),
    .rst_in      (rst_in),
    .async_in    (link_clk_in),
    .sync_out    (sclk_s)
  );

  link_sync2 #(
    .RST_VAL (pvpf_pkg::SEL_IDLE)
  ) u_sync_sel (
    .core_clk_in (core_clk_in),
    .rst_in      (rst_in),
    .async_in    (link_sel_n_in),
    .sync_out    (sel_n_s)
  );

  // ----------------------------------------------------------------
  // Field extraction from the setup registers
  // ----------------------------------------------------------------
  assign slot      = st_r.vec[pvpf_pkg::VEC_SLOT_LSB +: 7];
  assign phase     = st_r.vec[pvpf_pkg::VEC_PHASE_LSB +: 2];
  assign vtype     = st_r.vec[pvpf_pkg::VEC_TYPE_LSB +: 3];
  assign long_addr = st_r.vec[pvpf_pkg::VEC_LONG];
  assign bit_errs  = st_r.vec[pvpf_pkg::VEC_BERR_LSB +: 2];
  assign chk_fail  = st_r.vec[pvpf_pkg::VEC_CHKFAIL];
  assign chk       = st_r.num[pvpf_pkg::NUM_CHK_LSB +: 4];
  assign len       = st_r.num[pvpf_pkg::NUM_LEN_LSB +: 7];
  assign start     = st_r.num[pvpf_pkg::NUM_START_LSB +: 7];
  assign mtype     = st_r.shrt[pvpf_pkg::SH_MTYPE_LSB +: 2];
  assign chars     = st_r.shrt[pvpf_pkg::SH_CHARS_LSB +: 12];
  assign src       = st_r.shrt[pvpf_pkg::SH_SRC_LSB +: 3];
  assign msgnum    = st_r.shrt[pvpf_pkg::SH_MNUM_LSB +: 6];
  assign retr      = st_r.shrt[pvpf_pkg::SH_RETR];

  // ----------------------------------------------------------------
  // Vector classification and validity
  // ----------------------------------------------------------------
  assign is_short = (vtype == pvpf_pkg::VT_SHORT);
  assign is_num   = (vtype == pvpf_pkg::VT_NUM_STD)
                  | (vtype == pvpf_pkg::VT_NUM_SPEC)
                  | (vtype == pvpf_pkg::VT_NUM_NUMB);
  assign is_blk   = (vtype == pvpf_pkg::VT_SECURE)
                  | (vtype == pvpf_pkg::VT_ALPHA)
                  | (vtype == pvpf_pkg::VT_HEX);
  assign slot_bad  = (slot < pvpf_pkg::SLOT_MIN) | (slot > pvpf_pkg::SLOT_MAX);
  assign start_bad = (start < pvpf_pkg::START_MIN) | (start > pvpf_pkg::START_MAX);
  assign len_bad   = (len == 7'h00)
                   | (is_num & (len > pvpf_pkg::NUM_LEN_MAX))
                   | (is_blk & (len > pvpf_pkg::BLK_LEN_MAX));
  // Instruction vectors are not built here, so that code counts as invalid
  assign invalid   = slot_bad | (vtype == pvpf_pkg::VT_INSTR)
                   | ((is_num | is_blk) & (start_bad | len_bad));
  assign vec_err   = (bit_errs > pvpf_pkg::BIT_ERR_LIMIT) | chk_fail | invalid;

  // ----------------------------------------------------------------
  // Packet assembly; every unused position is zero
  // ----------------------------------------------------------------
  // Spare message type sends zero data rather than stale characters
  assign short_data = (mtype == pvpf_pkg::MT_NUMERIC) ? chars
                    : (mtype == pvpf_pkg::MT_SOURCE)  ? {9'h000, src}
                    : (mtype == pvpf_pkg::MT_SRC_MSG) ? {2'h0, retr, msgnum, src}
                    : 12'h000;
  assign len_m1     = len - 7'h01;
  assign pkt_body   = is_short ? {2'h0, short_data, mtype}
                    : is_num   ? {2'h0, chk, len_m1[2:0], start}
                    : is_blk   ? {2'h0, len, start}
                    : 16'h0000;
  assign packet     = {1'h0, slot, vec_err, phase, 2'h0, vtype, pkt_body};
  // Follow-on packet sits in the slot right after the vector
  assign slot_next  = slot + 7'h01;
  assign extra_word = {1'h0, slot_next, 4'h0, st_r.extra[19:0]};

  // ----------------------------------------------------------------
  // Bus decode helpers
  // ----------------------------------------------------------------
  assign accept = (avs_read_in | avs_write_in) & ~st_r.wait_r;
  assign launch = accept & avs_write_in & (avs_address_in == pvpf_pkg::OFS_CMD)
                & avs_byteenable_in[0] & avs_writedata_in[pvpf_pkg::CMD_SEND]
                & ~st_r.busy;
  assign wmask  = {{8{avs_byteenable_in[3]}}, {8{avs_byteenable_in[2]}},
                   {8{avs_byteenable_in[1]}}, {8{avs_byteenable_in[0]}}};

  // ----------------------------------------------------------------
  // Next state: bus slave, register writes and packet sequencing
  // ----------------------------------------------------------------
  always_comb begin
    logic [31:0] rd;
    logic [31:0] wval;
    rd     = 32'h0000_0000;
    wval   = avs_writedata_in & wmask;
    st_nxt = st_r;
    st_nxt.load = 1'h0;
    // Read mux; unmapped offsets read zero
    case (avs_address_in)
      pvpf_pkg::OFS_VEC:    rd = st_r.vec;
      pvpf_pkg::OFS_NUM:    rd = st_r.num;
      pvpf_pkg::OFS_SHORT:  rd = st_r.shrt;
      pvpf_pkg::OFS_EXTRA:  rd = st_r.extra;
      pvpf_pkg::OFS_STATUS: begin
        rd[pvpf_pkg::ST_BUSY]  = st_r.busy;
        rd[pvpf_pkg::ST_EXTRA] = st_r.extra_pend;
        rd[pvpf_pkg::ST_ERR]   = st_r.last_err;
        rd[pvpf_pkg::ST_READY] = sh_ready;
      end
      pvpf_pkg::OFS_LAST:   rd = st_r.last_pkt;
      default:              rd = 32'h0000_0000;
    endcase
    // One wait cycle on every access, answer in the next
    if ((avs_read_in || avs_write_in) && st_r.wait_r) begin
      st_nxt.wait_r = 1'h0;
      st_nxt.rdata  = rd;
    end else begin
      st_nxt.wait_r = 1'h1;
    end
    // Setup writes; byte lanes merge into the stored word
    if (accept && avs_write_in) begin
      case (avs_address_in)
        pvpf_pkg::OFS_VEC:
          st_nxt.vec = ((st_r.vec & ~wmask) | wval) & pvpf_pkg::VEC_MASK;
        pvpf_pkg::OFS_NUM:
          st_nxt.num = ((st_r.num & ~wmask) | wval) & pvpf_pkg::NUM_MASK;
        pvpf_pkg::OFS_SHORT:
          st_nxt.shrt = ((st_r.shrt & ~wmask) | wval) & pvpf_pkg::SHORT_MASK;
        pvpf_pkg::OFS_EXTRA:
          st_nxt.extra = ((st_r.extra & ~wmask) | wval) & pvpf_pkg::EXTRA_MASK;
        default: begin
        end
      endcase
    end
    // Send command; ignored while a packet is still outstanding
    if (launch) begin
      st_nxt.load       = 1'h1;
      st_nxt.load_word  = packet;
      st_nxt.last_pkt   = packet;
      st_nxt.ext_word   = extra_word;
      st_nxt.busy       = 1'h1;
      st_nxt.last_err   = vec_err;
      st_nxt.extra_pend = is_short & long_addr & ~vec_err;
    end
    // Packet read out by the host: chain the follow-on or go idle
    if (sh_done && st_r.busy) begin
      if (st_r.extra_pend) begin
        st_nxt.load       = 1'h1;
        st_nxt.load_word  = st_r.ext_word;
        st_nxt.last_pkt   = st_r.ext_word;
        st_nxt.extra_pend = 1'h0;
      end else begin
        st_nxt.busy = 1'h0;
      end
    end
  end

  // State register
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      st_r        <= '0;
      st_r.wait_r <= pvpf_pkg::WAIT_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Serial link to the host
  // ----------------------------------------------------------------
  packet_shift_out u_shift (
    .core_clk_in (core_clk_in),
    .rst_in      (rst_in),
    .load_in     (st_r.load),
    .word_in     (st_r.load_word),
    .sclk_in     (sclk_s),
    .sel_n_in    (sel_n_s),
    .data_out    (link_data_out),
    .oe_out      (link_data_oe_out),
    .ready_out   (sh_ready),
    .done_out    (sh_done)
  );

  assign link_ready_out      = sh_ready;
  assign avs_readdata_out    = st_r.rdata;
  assign avs_waitrequest_out = st_r.wait_r;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (rst_in);

  sequence s_bus_req;
    (avs_read_in || avs_write_in) && st_r.wait_r;
  endsequence

  sequence s_first_done;
    sh_done && st_r.busy && st_r.extra_pend;
  endsequence

  AST_BUS_ONE_WAIT: assert property (
    s_bus_req |=> !avs_waitrequest_out ##1 avs_waitrequest_out
  ) else $error("waitrequest did not answer in one cycle");

  AST_TOP_BYTE: assert property (
    launch |=> st_r.load && st_r.load_word[31] == 1'h0
               && st_r.load_word[30:24] == $past(slot)
  ) else $error("top byte does not carry slot index");

  AST_ERR_BITS: assert property (
    launch && (bit_errs == 2'h3 || chk_fail || slot_bad) |=> st_r.load_word[23]
  ) else $error("error flag missing");

  AST_PHASE: assert property (
    launch |=> st_r.load_word[22:21] == $past(phase)
  ) else $error("phase field wrong");

  AST_TYPE_UNUSED: assert property (
    launch |=> st_r.load_word[18:16] == $past(vtype)
               && st_r.load_word[20:19] == 2'h0
               && st_r.load_word[15:14] == 2'h0
  ) else $error("type field or unused bits wrong");

  AST_SOURCE_ONLY: assert property (
    launch && is_short && mtype == 2'h1
      |=> st_r.load_word[13:2] == {9'h000, $past(src)}
  ) else $error("source-only data wrong");

  AST_SOURCE_MSG: assert property (
    launch && is_short && mtype == 2'h2
      |=> st_r.load_word[13:2] == {2'h0, $past(retr), $past(msgnum), $past(src)}
  ) else $error("source and message number data wrong");

  AST_NUM_COUNT: assert property (
    launch && is_num |=> st_r.load_word[9:7] == $past(len[2:0]) - 3'h1
                         && st_r.load_word[13:10] == $past(chk)
  ) else $error("numeric count or check bits wrong");

  AST_BLK_COUNT: assert property (
    launch && is_blk |=> st_r.load_word[13:7] == $past(len)
                         && st_r.load_word[6:0] == $past(start)
  ) else $error("block vector count or start wrong");

  AST_NO_EXTRA_ON_ERR: assert property (
    launch && vec_err |=> !st_r.extra_pend ##1 !st_r.load
  ) else $error("follow-on packet pending after error");

  AST_EXTRA_CHAIN: assert property (
    s_first_done |=> st_r.load && st_r.busy
                     && st_r.load_word[30:24] == $past(st_r.ext_word[30:24])
  ) else $error("follow-on packet not loaded");

endmodule

// File: logic/pvpf_pkg.sv
// Shared constants for the paging vector packet formatter
package pvpf_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [4:0] OFS_CMD    = 5'h00;
  localparam logic [4:0] OFS_VEC    = 5'h04;
  localparam logic [4:0] OFS_NUM    = 5'h08;
  localparam logic [4:0] OFS_SHORT  = 5'h0C;
  localparam logic [4:0] OFS_EXTRA  = 5'h10;
  localparam logic [4:0] OFS_STATUS = 5'h14;
  localparam logic [4:0] OFS_LAST   = 5'h18;

  // ----------------------------------------------------------------
  // Register field positions and writable masks
  // ----------------------------------------------------------------
  localparam int CMD_SEND      = 0;
  localparam int VEC_SLOT_LSB  = 0;
  localparam int VEC_PHASE_LSB = 7;
  localparam int VEC_TYPE_LSB  = 9;
  localparam int VEC_LONG      = 12;
  localparam int VEC_BERR_LSB  = 13;
  localparam int VEC_CHKFAIL   = 15;
  localparam int NUM_CHK_LSB   = 0;
  localparam int NUM_LEN_LSB   = 4;
  localparam int NUM_START_LSB = 11;
  localparam int SH_MTYPE_LSB  = 0;
  localparam int SH_CHARS_LSB  = 2;
  localparam int SH_SRC_LSB    = 14;
  localparam int SH_MNUM_LSB   = 17;
  localparam int SH_RETR       = 23;
  localparam int ST_BUSY       = 0;
  localparam int ST_EXTRA      = 1;
  localparam int ST_ERR        = 2;
  localparam int ST_READY      = 3;
  localparam logic [31:0] VEC_MASK   = 32'h0000_FFFF;
  localparam logic [31:0] NUM_MASK   = 32'h0003_FFFF;
  localparam logic [31:0] SHORT_MASK = 32'h00FF_FFFF;
  localparam logic [31:0] EXTRA_MASK = 32'h000F_FFFF;

  // ----------------------------------------------------------------
  // Vector type and message type codes
  // ----------------------------------------------------------------
  localparam logic [2:0] VT_SECURE   = 3'h0;
  localparam logic [2:0] VT_INSTR    = 3'h1;
  localparam logic [2:0] VT_SHORT    = 3'h2;
  localparam logic [2:0] VT_NUM_STD  = 3'h3;
  localparam logic [2:0] VT_NUM_SPEC = 3'h4;
  localparam logic [2:0] VT_ALPHA    = 3'h5;
  localparam logic [2:0] VT_HEX      = 3'h6;
  localparam logic [2:0] VT_NUM_NUMB = 3'h7;
  localparam logic [1:0] MT_NUMERIC  = 2'h0;
  localparam logic [1:0] MT_SOURCE   = 2'h1;
  localparam logic [1:0] MT_SRC_MSG  = 2'h2;

  // ----------------------------------------------------------------
  // Limits, counts and reset values
  // ----------------------------------------------------------------
  localparam logic [6:0]  SLOT_MIN      = 7'h02;
  localparam logic [6:0]  SLOT_MAX      = 7'h57;
  localparam logic [6:0]  START_MIN     = 7'h03;
  localparam logic [6:0]  START_MAX     = 7'h57;
  localparam logic [6:0]  NUM_LEN_MAX   = 7'h08;
  localparam logic [6:0]  BLK_LEN_MAX   = 7'h55;
  localparam logic [1:0]  BIT_ERR_LIMIT = 2'h2;
  localparam logic [5:0]  PKT_LAST_BIT  = 6'h1F;
  localparam logic        WAIT_RST      = 1'h1;
  localparam logic        SEL_IDLE      = 1'h1;
  localparam logic [31:0] WORD_RST      = 32'h0000_0000;

endpackage

// File: verification/host_reader.sv
// Host model that pulls 32-bit packets over the serial link
`timescale 1ns/1ps
module host_reader (
  input  wire logic        ready_in,
  input  wire logic        data_in,
  input  wire logic        oe_in,
  output logic             sclk_out,
  output logic             sel_n_out,
  output logic [31:0]      word_out,
  output logic             got_out
);
  // ----------------------------------------------------------------
  // Read loop: select, settle, 32 clocks, sample on rising edge
  // ----------------------------------------------------------------
  // Bits are stored raw; unused fields are left to the bench to judge
  initial begin
    sclk_out  = 1'b0;
    sel_n_out = 1'b1;
    word_out  = 32'h0000_0000;
    got_out   = 1'b0;
    forever begin
      wait (ready_in === 1'b1);
      #300 sel_n_out = 1'b0;
      #200;
      for (int i = 31; i >= 0; i--) begin
        #100 sclk_out = 1'b1;
        word_out[i] = data_in & oe_in; // Undriven line reads as zero
        #100 sclk_out = 1'b0;
      end
      #100 sel_n_out = 1'b1;
      got_out = 1'b1;
      #25 got_out = 1'b0;
      #300;
    end
  end
endmodule

// File: verification/testbench.sv
// Self-checking bench for the vector packet formatter
`timescale 1ns/1ps
module testbench;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [4:0]  addr = 5'h00;
  logic        rd_s = 1'b0;
  logic        wr_s = 1'b0;
  logic [31:0] wdata = 32'h0000_0000;
  logic [3:0]  be = 4'hf;
  logic [31:0] rdata;
  logic        wait_s;
  logic        lclk, lsel_n, ldata, loe, lready, got;
  logic [31:0] hw, r, rd, ex;
  logic [11:0] d12;
  logic [6:0]  sl, ln, st;
  logic [2:0]  tt [6] = '{pvpf_pkg::VT_NUM_STD, pvpf_pkg::VT_NUM_SPEC, pvpf_pkg::VT_NUM_NUMB,
                          pvpf_pkg::VT_SECURE, pvpf_pkg::VT_ALPHA, pvpf_pkg::VT_HEX};
  logic [31:0] q [$];
  int          miscompares = 0;
  int          samples_checked = 0;
  int          seed = 32'hec24;

  initial begin
    forever #12.5 clk = ~clk;
  end

  paging_vector_packet_formatter i_dut (.core_clk_in(clk), .rst_in(rst), .avs_address_in(addr),
    .avs_read_in(rd_s), .avs_write_in(wr_s), .avs_writedata_in(wdata),
    .avs_byteenable_in(be), .avs_readdata_out(rdata), .avs_waitrequest_out(wait_s),
    .link_clk_in(lclk), .link_sel_n_in(lsel_n), .link_data_out(ldata),
    .link_data_oe_out(loe), .link_ready_out(lready));
  host_reader i_host (.ready_in(lready), .data_in(ldata), .oe_in(loe), .sclk_out(lclk),
    .sel_n_out(lsel_n), .word_out(hw), .got_out(got));

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic end_of_test();
    if (miscompares == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end
    else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  // Avalon access: hold until waitrequest is seen low at an edge
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d,
                     output logic [31:0] qd);
    int n;
    n = 0;
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr_s  <= w;
    rd_s  <= ~w;
    do begin
      @(posedge clk);
      n++;
    end while (wait_s !== 1'b0 && n < 50);
    qd = rdata;
    wr_s <= 1'b0;
    rd_s <= 1'b0;
    if (n == 50) begin
      miscompares++;
      end_of_test();
    end
  endtask

  function automatic logic [31:0] vec(logic c, logic [1:0] b, logic l, logic [2:0] t,
                                      logic [1:0] p, logic [6:0] s);
    return {16'h0000, c, b, l, t, p, s};
  endfunction

  function automatic logic [31:0] pkt(logic [6:0] s, logic e, logic [1:0] p, logic [2:0] t,
                                      logic [15:0] b);
    return {1'b0, s, e, p, 2'b00, t, b};
  endfunction

  // Set up, note the expected word, send, wait until the host has it all
  task automatic go(input logic [31:0] v, input logic [4:0] a, input logic [31:0] d,
                    input logic [31:0] e, input logic f);
    int n;
    n = 0;
    bus(1'b1, pvpf_pkg::OFS_VEC, v, rd);
    bus(1'b1, a, d, rd);
    q.push_back(e);
    if (f) begin
      q.push_back({1'b0, v[6:0] + 7'h01, 4'h0, r[19:0]});
    end
    bus(1'b1, pvpf_pkg::OFS_CMD, 32'h0000_0001, rd);
    while (q.size() != 0 && n < 20000) begin
      @(posedge clk);
      n++;
    end
    if (n == 20000) begin
      miscompares++;
      end_of_test();
    end
  endtask

  // Every packet the host finishes is checked against the oldest note
  always @(posedge got) begin
    cmp(hw, q.size() ? q.pop_front() : 32'hxxxx_xxxx);
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    bus(1'b0, pvpf_pkg::OFS_STATUS, 32'h0, rd);
    cmp(rd, 32'h0000_0000);
    bus(1'b0, 5'h1C, 32'h0, rd);
    cmp(rd, 32'h0000_0000);
    // One byte lane only: the other lanes keep their old zero
    be <= 4'h1;
    bus(1'b1, pvpf_pkg::OFS_NUM, 32'hffff_ffff, rd);
    be <= 4'hf;
    bus(1'b0, pvpf_pkg::OFS_NUM, 32'h0, rd);
    cmp(rd, 32'h0000_00ff);
    // All four short message types, random fields and phase
    for (int m = 0; m < 4; m++) begin
      r = $random(seed);
      sl = 7'h02 + 7'(r[30:24] % 86);
      d12 = m == 0 ? r[13:2] : m == 1 ? {9'h0, r[16:14]} :
            m == 2 ? {2'h0, r[23], r[22:17], r[16:14]} : 12'h000;
      go(vec(0, 0, 0, pvpf_pkg::VT_SHORT, r[8:7], sl), pvpf_pkg::OFS_SHORT, {r[31:2], 2'(m)},
         pkt(sl, 0, r[8:7], pvpf_pkg::VT_SHORT, {2'h0, d12, 2'(m)}), 0);
    end
    // Long address: five characters follow; two bit errors still clean
    r = $random(seed);
    bus(1'b1, pvpf_pkg::OFS_EXTRA, r, rd);
    go(vec(0, 2, 1, pvpf_pkg::VT_SHORT, 3, 2), pvpf_pkg::OFS_SHORT, 32'h3,
       pkt(2, 0, 3, pvpf_pkg::VT_SHORT, 16'h0003), 1);
    // Error flag sources; no follow-on may appear after them
    go(vec(0, 3, 1, pvpf_pkg::VT_SHORT, 1, 87), pvpf_pkg::OFS_SHORT, 32'h3,
       pkt(87, 1, 1, pvpf_pkg::VT_SHORT, 16'h0003), 0);
    go(vec(1, 0, 1, pvpf_pkg::VT_SHORT, 2, 9), pvpf_pkg::OFS_SHORT, 32'h3,
       pkt(9, 1, 2, pvpf_pkg::VT_SHORT, 16'h0003), 0);
    go(vec(0, 0, 0, pvpf_pkg::VT_INSTR, 0, 5), pvpf_pkg::OFS_SHORT, 32'h3,
       pkt(5, 1, 0, pvpf_pkg::VT_INSTR, 16'h0000), 0);
    // Start or length out of range flags an error, fields still carried
    go(vec(0, 0, 0, pvpf_pkg::VT_NUM_STD, 1, 40), pvpf_pkg::OFS_NUM,
       {14'h0, 7'h02, 7'h09, 4'h5},
       pkt(40, 1, 1, pvpf_pkg::VT_NUM_STD, {2'h0, 4'h5, 3'h0, 7'h02}), 0);
    go(vec(0, 0, 0, pvpf_pkg::VT_HEX, 2, 60), pvpf_pkg::OFS_NUM,
       {14'h0, 7'h57, 7'h56, 4'h0},
       pkt(60, 1, 2, pvpf_pkg::VT_HEX, {2'h0, 7'h56, 7'h57}), 0);
    // Numeric and block types with length and start boundaries
    for (int i = 0; i < 6; i++) begin
      r = $random(seed);
      sl = 7'h02 + 7'(r[30:24] % 86);
      ln = i % 3 == 0 ? 7'h01 : i < 3 ? 7'h08 : 7'h55;
      st = i % 3 == 1 ? 7'h57 : 7'h03 + 7'(r[22:16] % 85);
      ex = pkt(sl, 0, r[8:7], tt[i], i < 3 ? {2'h0, r[3:0], 3'(ln - 1), st} : {2'h0, ln, st});
      go(vec(0, 0, 0, tt[i], r[8:7], sl), pvpf_pkg::OFS_NUM, {14'h0, st, ln, r[3:0]},
         ex, 0);
    end
    bus(1'b0, pvpf_pkg::OFS_LAST, 32'h0, rd);
    cmp(rd, ex);
    end_of_test();
  end
endmodule
